// ===== hw/b2vc_params.svh
`ifndef B2VC_PARAMS_SVH
`define B2VC_PARAMS_SVH

// register indices; byte address is four times the index
`define B2VC_IDX_CTRL 32'h0000_0017
`define B2VC_IDX_APPLY 32'h0000_001a
`define B2VC_IDX_STATUS 32'h0000_0030
`define B2VC_ADDR_CTRL (`B2VC_IDX_CTRL * 32'h0000_0004)
`define B2VC_ADDR_APPLY (`B2VC_IDX_APPLY * 32'h0000_0004)
`define B2VC_ADDR_STATUS (`B2VC_IDX_STATUS * 32'h0000_0004)

// control register fields
`define B2VC_CTRL_RESET 8'hb2
`define B2VC_BIT_PULSE_SKIP 7
`define B2VC_BIT_RESERVED 6
`define B2VC_CODE_MSB 5
`define B2VC_CODE_LSB 0
`define B2VC_CODE_RESET 6'h32
`define B2VC_PULSE_SKIP_RESET 1'h1

// apply register fields
`define B2VC_BIT_APPLY_NOW 0
`define B2VC_BIT_APPLY_ON_DISABLE 1

// status register fields
`define B2VC_BIT_STAT_BLANK 7
`define B2VC_BIT_STAT_PEND 6

// blanking time
`define B2VC_BLANK_MS 5
`define B2VC_CLK_KHZ 100000
`define B2VC_BLANK_W 19

// bus answers
`define B2VC_RESP_OKAY 2'h0
`define B2VC_RESP_SLVERR 2'h2

`endif

// ===== hw/b2vc_pkg.sv
package b2vc_pkg;
  typedef logic [5:0] b2vc_code_t;
  typedef logic [1:0] b2vc_resp_t;
  typedef logic [31:0] b2vc_word_t;
  typedef logic [3:0] b2vc_strb_t;
endpackage

// ===== hw/b2vc_reg.sv
// Overview of operation
// - Any write to the control register blanks the converter's over- and under-voltage monitors for 5 ms.
// - A newly written voltage code reaches the converter only after software sets the immediate or the on-disable apply bit.
// - Bit 7 enables pulse-skip, resets to one, and zero forces fixed-frequency operation.
// - Bit 6 is reserved and always reads zero.
// - Bits 5 to 0 hold the output-voltage code, stepping 10 mV up to code 32h and 25 mV above it.
// - The control register sits at index 17h and resets to b2h.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "b2vc_params.svh"

module b2vc_reg #(
  parameter int unsigned BLANK_CYCLES =
    `B2VC_BLANK_MS * `B2VC_CLK_KHZ
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire b2vc_pkg::b2vc_word_t s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire b2vc_pkg::b2vc_word_t s_axi_wdata,
  input wire b2vc_pkg::b2vc_strb_t s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output b2vc_pkg::b2vc_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire b2vc_pkg::b2vc_word_t s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output b2vc_pkg::b2vc_word_t s_axi_rdata,
  output b2vc_pkg::b2vc_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic converterEnabled,
  output logic pulseSkipEnable,
  output b2vc_pkg::b2vc_code_t activeVoltageCode,
  output logic monitorBlank
);
  import b2vc_pkg::*;

  // write channel holding registers
  logic awHeld_q;
  logic awHeld_d;
  b2vc_word_t awAddr_q;
  b2vc_word_t awAddr_d;
  logic wHeld_q;
  logic wHeld_d;
  b2vc_word_t wData_q;
  b2vc_word_t wData_d;
  b2vc_strb_t wStrb_q;
  b2vc_strb_t wStrb_d;
  logic bValid_q;
  logic bValid_d;
  b2vc_resp_t bResp_q;
  b2vc_resp_t bResp_d;

  // read channel
  logic rValid_q;
  logic rValid_d;
  b2vc_word_t rData_q;
  b2vc_word_t rData_d;
  b2vc_resp_t rResp_q;
  b2vc_resp_t rResp_d;

  // register state
  logic pulseSkip_q;
  logic pulseSkip_d;
  b2vc_code_t code_q;
  b2vc_code_t code_d;
  b2vc_code_t active_q;
  b2vc_code_t active_d;
  logic applyPend_q;
  logic applyPend_d;
  logic [`B2VC_BLANK_W-1:0] blankCnt_q;
  logic [`B2VC_BLANK_W-1:0] blankCnt_d;

  // handshakes
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire bDone = s_axi_bvalid && s_axi_bready;
  wire rDone = s_axi_rvalid && s_axi_rready;

  // one write in flight: both halves held, then answer
  wire writeFire = awHeld_q && wHeld_q && !bValid_q;

  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready = !wHeld_q && !bValid_q;
  assign s_axi_arready = !rValid_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;

  // write decode
  // control register address
  wire wrHitCtrl = (awAddr_q == `B2VC_ADDR_CTRL);
  wire wrHitApply = (awAddr_q == `B2VC_ADDR_APPLY);
  wire wrHitStatus = (awAddr_q == `B2VC_ADDR_STATUS);
  wire wrMapped = wrHitCtrl || wrHitApply || wrHitStatus;
  wire lane0 = wStrb_q[0];
  wire ctrlWrite = writeFire && wrHitCtrl;
  wire ctrlLoad = ctrlWrite && lane0;
  wire applyLoad = writeFire && wrHitApply && lane0;
  wire applyNowReq = applyLoad && wData_q[`B2VC_BIT_APPLY_NOW];
  wire applyDisReq = applyLoad && wData_q[`B2VC_BIT_APPLY_ON_DISABLE];

  // hand over on disable when armed
  wire applyOnOff = applyPend_q && !converterEnabled;
  wire applyTransfer = applyNowReq || applyOnOff;

  // read decode
  wire rdHitCtrl = (s_axi_araddr == `B2VC_ADDR_CTRL);
  wire rdHitApply = (s_axi_araddr == `B2VC_ADDR_APPLY);
  wire rdHitStatus = (s_axi_araddr == `B2VC_ADDR_STATUS);
  wire rdMapped = rdHitCtrl || rdHitApply || rdHitStatus;

  // reserved bit forced low on read
  wire [7:0] ctrlView = {pulseSkip_q, 1'h0, code_q};
  wire [7:0] applyView = {6'h00, applyPend_q, 1'h0};
  wire [7:0] statusView = {monitorBlank, applyPend_q, active_q};
  wire [7:0] rdByte = rdHitCtrl ? ctrlView :
                      rdHitApply ? applyView :
                      rdHitStatus ? statusView : 8'h00;

  wire blankActive = (blankCnt_q != '0);

  always_comb begin
    awHeld_d = awHeld_q;
    awAddr_d = awAddr_q;
    wHeld_d = wHeld_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    bValid_d = bValid_q;
    bResp_d = bResp_q;
    if (awTake) begin
      awHeld_d = 1'h1;
      awAddr_d = s_axi_awaddr;
    end
    if (wTake) begin
      wHeld_d = 1'h1;
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
    end
    if (writeFire) begin
      awHeld_d = 1'h0;
      wHeld_d = 1'h0;
      bValid_d = 1'h1;
      bResp_d = wrMapped ? `B2VC_RESP_OKAY : `B2VC_RESP_SLVERR;
    end
    if (bDone) begin
      bValid_d = 1'h0;
    end
  end

  always_comb begin
    rValid_d = rValid_q;
    rData_d = rData_q;
    rResp_d = rResp_q;
    if (arTake) begin
      rValid_d = 1'h1;
      rData_d = {24'h00_0000, rdByte};
      rResp_d = rdMapped ? `B2VC_RESP_OKAY : `B2VC_RESP_SLVERR;
    end else if (rDone) begin
      rValid_d = 1'h0;
    end
  end

  always_comb begin
    pulseSkip_d = pulseSkip_q;
    code_d = code_q;
    if (ctrlLoad) begin
      pulseSkip_d = wData_q[`B2VC_BIT_PULSE_SKIP];
    end
    if (ctrlLoad) begin
      code_d = wData_q[`B2VC_CODE_MSB:`B2VC_CODE_LSB];
    end
    // bit 6 of write data never stored
  end

  always_comb begin
    active_d = active_q;
    applyPend_d = applyPend_q;
    // code reaches converter only on apply
    if (applyTransfer) begin
      active_d = code_q;
    end
    if (applyOnOff) begin
      applyPend_d = 1'h0;
    end
    // software arming wins over hardware clear
    if (applyDisReq) begin
      applyPend_d = 1'h1;
    end
  end

  always_comb begin
    blankCnt_d = blankCnt_q;
    // restart blanking on every control write
    if (ctrlWrite) begin
      blankCnt_d = BLANK_CYCLES[`B2VC_BLANK_W-1:0];
    end else if (blankActive) begin
      blankCnt_d = blankCnt_q - `B2VC_BLANK_W'(1);
    end
  end

  assign pulseSkipEnable = pulseSkip_q;
  assign activeVoltageCode = active_q;
  assign monitorBlank = blankActive;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld_q <= 1'h0;
      awAddr_q <= 32'h0000_0000;
      wHeld_q <= 1'h0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      bValid_q <= 1'h0;
      bResp_q <= `B2VC_RESP_OKAY;
    end else begin
      awHeld_q <= awHeld_d;
      awAddr_q <= awAddr_d;
      wHeld_q <= wHeld_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      bValid_q <= bValid_d;
      bResp_q <= bResp_d;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rValid_q <= 1'h0;
      rData_q <= 32'h0000_0000;
      rResp_q <= `B2VC_RESP_OKAY;
    end else begin
      rValid_q <= rValid_d;
      rData_q <= rData_d;
      rResp_q <= rResp_d;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulseSkip_q <= `B2VC_PULSE_SKIP_RESET;
      code_q <= `B2VC_CODE_RESET;
      active_q <= `B2VC_CODE_RESET;
      applyPend_q <= 1'h0;
      blankCnt_q <= '0;
    end else begin
      pulseSkip_q <= pulseSkip_d;
      code_q <= code_d;
      active_q <= active_d;
      applyPend_q <= applyPend_d;
      blankCnt_q <= blankCnt_d;
    end
  end

endmodule

// ===== verification/b2vc_assertions.sv
`timescale 1ns/10ps
`include "b2vc_params.svh"
module b2vc_chk #(
  parameter int unsigned BLANK_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire b2vc_pkg::b2vc_word_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire b2vc_pkg::b2vc_word_t s_axi_rdata,
  input wire logic converterEnabled,
  input wire logic pulseSkipEnable,
  input wire b2vc_pkg::b2vc_code_t activeVoltageCode,
  input wire logic monitorBlank
);
  import b2vc_pkg::*;
  logic rdCtrl_q;
  logic [19:0] sinceWr_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // any write restarts it, so the bound is loose but never false
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdCtrl_q <= 1'b0;
      sinceWr_q <= 20'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        rdCtrl_q <= (s_axi_araddr == `B2VC_ADDR_CTRL);
      end
      sinceWr_q <= $rose(s_axi_bvalid) ? 20'h0 : sinceWr_q + 20'h1;
    end
  end
  a_blank_start: assert property (
    $rose(monitorBlank) |-> $rose(s_axi_bvalid)) else $error("blank start");
  a_blank_len: assert property (
    monitorBlank && !$rose(s_axi_bvalid) |-> sinceWr_q <= BLANK_CYCLES - 2)
    else $error("blank too long");
  a_code_hold: assert property (
    !$stable(activeVoltageCode) |->
      $rose(s_axi_bvalid) || !$past(converterEnabled))
    else $error("code changed unasked");
  a_psk_hold: assert property (
    !$stable(pulseSkipEnable) |-> $rose(s_axi_bvalid))
    else $error("pulse skip changed");
  a_resv_zero: assert property (
    s_axi_rvalid && rdCtrl_q |-> !s_axi_rdata[6]) else $error("bit 6 set");
  a_rd_pad: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits");
  a_rd_psk: assert property (
    s_axi_rvalid && rdCtrl_q |-> s_axi_rdata[7] == pulseSkipEnable)
    else $error("bit 7 mismatch");
  a_reset_val: assert property (disable iff (1'b0)
    sys_rst |-> pulseSkipEnable && activeVoltageCode == 6'h32 && !monitorBlank)
    else $error("reset value");
  cover property ($fell(monitorBlank));
  cover property (s_axi_rvalid && rdCtrl_q);
  cover property (!$stable(activeVoltageCode) && !converterEnabled);
endmodule
bind b2vc_reg b2vc_chk #(.BLANK_CYCLES(BLANK_CYCLES)) chk (.ref_clk,
  .sys_rst, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid,
  .s_axi_rvalid, .s_axi_rdata, .converterEnabled, .pulseSkipEnable,
  .activeVoltageCode, .monitorBlank);

// ===== verification/tb_top.sv
`timescale 1ns/10ps
`include "b2vc_params.svh"
module tb_top;
  import b2vc_pkg::*;
  localparam int BC = 20;
  // reset rises at time zero so the design sees a real reset edge
  logic ref_clk, sys_rst = 1'h0, converterEnabled = 1'h1;
  b2vc_word_t s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  b2vc_word_t s_axi_araddr = 32'h0, s_axi_rdata, rdVal;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, pulseSkipEnable, monitorBlank;
  b2vc_resp_t s_axi_bresp, s_axi_rresp, resp;
  b2vc_code_t activeVoltageCode;
  int mismatches = 0, check_count = 0, blankCnt = 0;
  b2vc_reg #(.BLANK_CYCLES(BC)) dut (.ref_clk, .sys_rst, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .converterEnabled, .pulseSkipEnable,
    .activeVoltageCode, .monitorBlank);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (monitorBlank) blankCnt <= blankCnt + 1;
  task print_verdict();
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input b2vc_word_t got, input b2vc_word_t exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input b2vc_word_t a, input b2vc_word_t d);
    int n;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
    if (n >= 50) begin
      mismatches++;
      print_verdict();
    end
  endtask
  task rd(input b2vc_word_t a);
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    rdVal = s_axi_rdata;
    resp = s_axi_rresp;
    if (n >= 50) begin
      mismatches++;
      print_verdict();
    end
  endtask
  task t_reset();
    rd(`B2VC_ADDR_CTRL);
    chk(rdVal, 32'hb2);
    chk({26'h0, activeVoltageCode}, 32'h32);
  endtask
  task t_fields();
    wr(`B2VC_ADDR_CTRL, 32'h7f);
    chk({31'h0, monitorBlank}, 32'h1);
    chk({31'h0, pulseSkipEnable}, 32'h0);
    chk({26'h0, activeVoltageCode}, 32'h32);
    rd(`B2VC_ADDR_CTRL);
    chk(rdVal, 32'h3f);
  endtask
  task t_blank();
    int n, s;
    // settle past the edge so the counter's update has landed
    for (n = 0; n < 100 && monitorBlank; n++) begin
      @(posedge ref_clk);
      #1;
    end
    if (monitorBlank) begin
      mismatches++;
      print_verdict();
    end
    s = blankCnt;
    wr(`B2VC_ADDR_CTRL, 32'h3f);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (monitorBlank && n < 100);
    if (monitorBlank) begin
      mismatches++;
      print_verdict();
    end
    chk(b2vc_word_t'(blankCnt - s), BC);
  endtask
  task t_apply();
    wr(`B2VC_ADDR_APPLY, 32'h1);
    chk({26'h0, activeVoltageCode}, 32'h3f);
    wr(`B2VC_ADDR_CTRL, 32'h85);
    wr(`B2VC_ADDR_APPLY, 32'h2);
    rd(`B2VC_ADDR_APPLY);
    chk(rdVal, 32'h2);
    repeat (3) @(posedge ref_clk);
    chk({26'h0, activeVoltageCode}, 32'h3f);
    chk({31'h0, pulseSkipEnable}, 32'h1);
    converterEnabled <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk({26'h0, activeVoltageCode}, 32'h05);
    rd(`B2VC_ADDR_APPLY);
    chk(rdVal, 32'h0);
    converterEnabled <= 1'h1;
  endtask
  task t_unmapped();
    rd(32'h5d);
    chk({30'h0, resp}, {30'h0, `B2VC_RESP_SLVERR});
    wr(32'h4, 32'h0);
    chk({30'h0, resp}, {30'h0, `B2VC_RESP_SLVERR});
    rd(`B2VC_ADDR_CTRL);
    chk(rdVal, 32'h85);
  endtask
  initial begin
    sys_rst <= 1'h1;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'h0;
    t_reset();
    t_fields();
    t_blank();
    t_apply();
    t_unmapped();
    print_verdict();
  end
endmodule
